// file: common/hcuw_map.vh
// Purpose: Constants for the host link serial port and its wake lines.
// Assumes: A 10 MHz core clock and a 24-bit phase accumulator baud source.
// Notes:   Baud increments are derived here from bit rates.
`ifndef HCUW_MAP_VH
`define HCUW_MAP_VH

`define HCUW_CLK_HZ        10000000
`define HCUW_NCO_BITS      24
`define HCUW_NCO_ONE       64'h0000000001000000
`define HCUW_NCO_HALF      24'h800000
`define HCUW_BAUD_DEFAULT  115200
`define HCUW_BAUD_MIN      115200
`define HCUW_BAUD_MAX      3000000
`define HCUW_NCO_INC(bps)  ((((bps) * `HCUW_NCO_ONE) + (`HCUW_CLK_HZ / 2)) / `HCUW_CLK_HZ)

`define HCUW_FRAME_BITS    4'h9
`define HCUW_STOP_INDEX    4'h9
`define HCUW_FIFO_DEPTH    1040
`define HCUW_FIFO_AW       11
`define HCUW_RTS_MARGIN    16

`define HCUW_WAKE_MODE_WAKE   1'b0
`define HCUW_WAKE_MODE_SLEEP  1'b1

`endif

// file: design/hcuw_fifo.v
// Purpose: Byte FIFO with a registered output stage.
// Assumes: Single clock, synchronous active-high reset.
// Notes:   Holds depth entries in the array plus one in the output stage.
`include "hcuw_map.vh"

module hcuw_fifo (
  input  wire                      core_clk,
  input  wire                      rst,
  input  wire                      wr_valid,
  output reg                       wr_ready,
  input  wire [7:0]                wr_data,
  output reg                       rd_valid,
  input  wire                      rd_ready,
  output reg  [7:0]                rd_data,
  output reg  [`HCUW_FIFO_AW-1:0]  level
);

  localparam [`HCUW_FIFO_AW-1:0] DEPTH = `HCUW_FIFO_DEPTH;
  localparam [`HCUW_FIFO_AW-1:0] LAST  = `HCUW_FIFO_DEPTH - 1;
  localparam [`HCUW_FIFO_AW-1:0] ONE   = 11'h001;

  reg  [7:0]               mem [0:`HCUW_FIFO_DEPTH-1];
  reg  [`HCUW_FIFO_AW-1:0] wr_ptr;
  reg  [`HCUW_FIFO_AW-1:0] rd_ptr;
  reg  [`HCUW_FIFO_AW-1:0] next_level;
  wire                     do_wr;
  wire                     do_rd;

  assign do_wr = wr_valid & wr_ready;
  assign do_rd = (level != 11'h000) & (~rd_valid | rd_ready);

  always @* begin
    next_level = level;
    if (do_wr & ~do_rd) begin
      next_level = level + ONE;
    end else if (do_rd & ~do_wr) begin
      next_level = level - ONE;
    end
  end

  always @(posedge core_clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= wr_data;
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      wr_ptr   <= 11'h000;
      rd_ptr   <= 11'h000;
      level    <= 11'h000;
      wr_ready <= 1'b1;
      rd_valid <= 1'b0;
      rd_data  <= 8'h00;
    end else begin
      level    <= next_level;
      wr_ready <= (next_level != DEPTH);
      if (do_wr) begin
        wr_ptr <= (wr_ptr == LAST) ? 11'h000 : wr_ptr + ONE;
      end
      if (do_rd) begin
        rd_ptr   <= (rd_ptr == LAST) ? 11'h000 : rd_ptr + ONE;
        rd_data  <= mem[rd_ptr];
        rd_valid <= 1'b1;
      end else if (rd_ready) begin
        rd_valid <= 1'b0;
      end
    end
  end

endmodule

// file: design/hcuw_uart.v
// Purpose: Four-wire host link serial port with deep FIFOs and wake lines.
// Assumes: Pins are synchronous to core_clk; the core frames H4 packets.
// Notes:   At 3 Mbps a bit is only about 3.3 clocks, so sampling jitter
//          of one clock eats into the shared rate error margin.
`include "hcuw_map.vh"

module hcuw_uart (
  input  wire                      core_clk,
  input  wire                      rst,
  input  wire                      uart_rxd,
  output reg                       uart_txd,
  output reg                       uart_rts_n,
  input  wire                      uart_cts_n,
  input  wire [31:0]               baud_rate,
  input  wire                      baud_load,
  input  wire [7:0]                tx_data,
  input  wire                      tx_valid,
  output wire                      tx_ready,
  output wire [7:0]                rx_data,
  output wire                      rx_valid,
  input  wire                      rx_ready,
  output reg                       rx_overrun,
  output reg                       rx_frame_err,
  input  wire                      wake_enable,
  input  wire                      wake_mode,
  input  wire                      device_wake_in,
  input  wire                      radio_idle,
  input  wire                      host_needed,
  output reg                       device_wake_in_req,
  output reg                       dev_sleep_ok,
  output reg                       host_wake
);

  localparam [63:0] INC_DEF_W = `HCUW_NCO_INC(`HCUW_BAUD_DEFAULT);
  localparam [63:0] INC_MIN_W = `HCUW_NCO_INC(`HCUW_BAUD_MIN);
  localparam [63:0] INC_MAX_W = `HCUW_NCO_INC(`HCUW_BAUD_MAX);
  localparam [`HCUW_FIFO_AW-1:0] RTS_LEVEL =
    `HCUW_FIFO_DEPTH - `HCUW_RTS_MARGIN;

  localparam TX_IDLE  = 1'b0;
  localparam TX_SHIFT = 1'b1;
  localparam RX_IDLE  = 1'b0;
  localparam RX_BITS  = 1'b1;

  // Rates outside the supported span are pinned to its ends.
  function [23:0] rate_to_inc;
    input [31:0] bps;
    reg   [63:0] inc;
    begin
      inc = ((({32'h0, bps} * `HCUW_NCO_ONE) + (`HCUW_CLK_HZ / 2)) /
             `HCUW_CLK_HZ);
      if (inc < INC_MIN_W) begin
        inc = INC_MIN_W;
      end else if (inc > INC_MAX_W) begin
        inc = INC_MAX_W;
      end
      rate_to_inc = inc[23:0];
    end
  endfunction

  reg  [23:0]              baud_inc;
  reg                      tx_state;
  reg  [23:0]              tx_acc;
  reg  [9:0]               tx_shift;
  reg  [3:0]               tx_bits;
  reg                      rx_state;
  reg  [23:0]              rx_acc;
  reg  [7:0]               rx_shift;
  reg  [3:0]               rx_bits;
  reg                      rx_prev;
  reg                      rxf_wr_valid;
  reg  [7:0]               rxf_wr_data;
  wire                     rxf_wr_ready;
  wire [`HCUW_FIFO_AW-1:0] rxf_level;
  wire                     txf_rd_valid;
  wire                     txf_rd_ready;
  wire [7:0]               txf_rd_data;
  wire [24:0]              tx_sum;
  wire [24:0]              rx_sum;

  assign tx_sum = {1'b0, tx_acc} + {1'b0, baud_inc};
  assign rx_sum = {1'b0, rx_acc} + {1'b0, baud_inc};

  // A new rate takes effect on the next clock in both directions, even mid-bit.
  always @(posedge core_clk) begin
    if (rst) begin
      baud_inc <= INC_DEF_W[23:0];
    end else if (baud_load) begin
      baud_inc <= rate_to_inc(baud_rate);
    end
  end

  // The same byte path carries programming and link traffic alike.
  hcuw_fifo u_tx_fifo (
    .core_clk (core_clk),
    .rst      (rst),
    .wr_valid (tx_valid),
    .wr_ready (tx_ready),
    .wr_data  (tx_data),
    .rd_valid (txf_rd_valid),
    .rd_ready (txf_rd_ready),
    .rd_data  (txf_rd_data),
    .level    ()
  );

  hcuw_fifo u_rx_fifo (
    .core_clk (core_clk),
    .rst      (rst),
    .wr_valid (rxf_wr_valid),
    .wr_ready (rxf_wr_ready),
    .wr_data  (rxf_wr_data),
    .rd_valid (rx_valid),
    .rd_ready (rx_ready),
    .rd_data  (rx_data),
    .level    (rxf_level)
  );

  // Clear-to-send is checked only between characters, never mid-frame.
  assign txf_rd_ready = (tx_state == TX_IDLE) & ~uart_cts_n;

  always @(posedge core_clk) begin
    if (rst) begin
      tx_state <= TX_IDLE;
      tx_acc   <= 24'h000000;
      tx_shift <= 10'h3FF;
      tx_bits  <= 4'h0;
      uart_txd <= 1'b1;
    end else begin
      case (tx_state)
        TX_IDLE: begin
          if (txf_rd_valid & txf_rd_ready) begin
            tx_shift <= {1'b1, txf_rd_data, 1'b0};
            uart_txd <= 1'b0;
            tx_acc   <= 24'h000000;
            tx_bits  <= 4'h0;
            tx_state <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          tx_acc <= tx_sum[23:0];
          if (tx_sum[24]) begin
            if (tx_bits == `HCUW_FRAME_BITS) begin
              tx_state <= TX_IDLE;
              uart_txd <= 1'b1;
            end else begin
              uart_txd <= tx_shift[1];
              tx_shift <= {1'b1, tx_shift[9:1]};
              tx_bits  <= tx_bits + 4'h1;
            end
          end
        end
        default: begin
          tx_state <= TX_IDLE;
        end
      endcase
    end
  end

  // Starting the phase at one half lands each sample mid-bit, which is
  // what leaves room for the shared rate error of both ends.
  always @(posedge core_clk) begin
    if (rst) begin
      rx_state     <= RX_IDLE;
      rx_acc       <= 24'h000000;
      rx_shift     <= 8'h00;
      rx_bits      <= 4'h0;
      rx_prev      <= 1'b1;
      rxf_wr_valid <= 1'b0;
      rxf_wr_data  <= 8'h00;
      rx_overrun   <= 1'b0;
      rx_frame_err <= 1'b0;
    end else begin
      rx_prev      <= uart_rxd;
      rxf_wr_valid <= 1'b0;
      rx_overrun   <= 1'b0;
      rx_frame_err <= 1'b0;
      case (rx_state)
        RX_IDLE: begin
          if (rx_prev & ~uart_rxd) begin
            rx_acc   <= `HCUW_NCO_HALF;
            rx_bits  <= 4'h0;
            rx_state <= RX_BITS;
          end
        end
        RX_BITS: begin
          rx_acc <= rx_sum[23:0];
          if (rx_sum[24]) begin
            rx_bits <= rx_bits + 4'h1;
            if (rx_bits == 4'h0) begin
              if (uart_rxd) begin
                rx_state <= RX_IDLE;
              end
            end else if (rx_bits == `HCUW_STOP_INDEX) begin
              rx_state <= RX_IDLE;
              if (uart_rxd) begin
                rxf_wr_valid <= rxf_wr_ready;
                rxf_wr_data  <= rx_shift;
                rx_overrun   <= ~rxf_wr_ready;
              end else begin
                rx_frame_err <= 1'b1;
              end
            end else begin
              rx_shift <= {uart_rxd, rx_shift[7:1]};
            end
          end
        end
        default: begin
          rx_state <= RX_IDLE;
        end
      endcase
    end
  end

  // The margin covers bytes a host still sends after seeing the drop.
  always @(posedge core_clk) begin
    if (rst) begin
      uart_rts_n <= 1'b1;
    end else begin
      uart_rts_n <= (rxf_level >= RTS_LEVEL);
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      device_wake_in_req <= 1'b0;
      dev_sleep_ok <= 1'b0;
      host_wake    <= 1'b0;
    end else if (~wake_enable) begin
      device_wake_in_req <= 1'b0;
      dev_sleep_ok <= 1'b0;
      host_wake    <= 1'b0;
    end else begin
      host_wake <= host_needed | txf_rd_valid;
      if (wake_mode == `HCUW_WAKE_MODE_WAKE) begin
        device_wake_in_req <= device_wake_in;
        dev_sleep_ok <= 1'b0;
      end else begin
        device_wake_in_req <= 1'b0;
        dev_sleep_ok <= ~device_wake_in & radio_idle;
      end
    end
  end

endmodule

// file: verification/hcuw_host_model.sv
// Purpose: Host side serial port facing the device pins.
// Assumes: Host bit timing uses the same increment as the device.
// Notes:   A low stop bit can be sent on purpose to provoke a fault.
module hcuw_host_model (
  input  wire logic core_clk,
  input  wire logic uart_txd,
  output logic      uart_rxd
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [23:0] inc = 24'h02F2FA;
  logic [7:0]  got;
  int          n_got = 0;
  initial uart_rxd = 1'b1;
  // Matching the device increment keeps the rate error far inside budget.
  task automatic tick(inout logic [24:0] acc);
    do begin
      @(posedge core_clk);
      acc = {1'b0, acc[23:0]} + {1'b0, inc};
    end while (!acc[24]);
  endtask
  task automatic send(input logic [7:0] b, input logic stop);
    logic [24:0] acc;
    logic [9:0]  f;
    acc = 25'h0000000;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      uart_rxd <= f[i];
      tick(acc);
    end
    if (!stop) uart_rxd <= 1'b1;
  endtask
  always begin : rx_side
    logic [24:0] acc;
    logic [9:0]  f;
    @(negedge uart_txd);
    acc = 25'h0800000;
    for (int i = 0; i < 10; i++) begin
      tick(acc);
      f[i] = uart_txd;
    end
    got = (f[9] === 1'b1 && f[0] === 1'b0) ? f[8:1] : 'x;
    n_got++;
  end
endmodule

// file: verification/hcuw_uart_chk.sv
// Purpose: Port assertions for the host link serial port.
// Assumes: One clock core_clk with synchronous active-high rst.
// Notes:   The pause check waits out more than one slow frame.
module hcuw_uart_chk (
  input logic       core_clk,
  input logic       rst,
  input logic       uart_txd,
  input logic       uart_cts_n,
  input logic       rx_valid,
  input logic       rx_ready,
  input logic [7:0] rx_data,
  input logic       rx_frame_err,
  input logic       wake_enable,
  input logic       wake_mode,
  input logic       device_wake_in,
  input logic       radio_idle,
  input logic       host_needed,
  input logic       device_wake_in_req,
  input logic       dev_sleep_ok,
  input logic       host_wake
);
  logic [10:0] held;
  // Saturates so a long pause never wraps back under the limit.
  always @(posedge core_clk) begin
    if (rst || !uart_cts_n) begin
      held <= 11'h000;
    end else if (held != 11'h7FF) begin
      held <= held + 11'h001;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_reset_idle: assert property ($past(rst) |-> uart_txd && !rx_valid)
    else $error("line not idle after reset");
  a_wake_gate: assert property (!wake_enable |=> !device_wake_in_req &&
    !dev_sleep_ok && !host_wake) else $error("wake outputs not gated");
  a_wake_follow: assert property (wake_enable && !wake_mode |=>
    device_wake_in_req == $past(device_wake_in) && !dev_sleep_ok)
    else $error("wake request wrong");
  a_sleep_permit: assert property (wake_enable && wake_mode |=>
    dev_sleep_ok == (!$past(device_wake_in) && $past(radio_idle))
    && !device_wake_in_req) else $error("sleep permit wrong");
  a_host_wake: assert property (wake_enable && host_needed |=> host_wake)
    else $error("host not woken");
  a_rx_hold: assert property (rx_valid && !rx_ready |=>
    rx_valid && $stable(rx_data)) else $error("receive byte not held");
  a_ferr_pulse: assert property (rx_frame_err |=> !rx_frame_err)
    else $error("framing pulse too long");
  a_cts_pause: assert property (held > 11'h3E8 |-> uart_txd)
    else $error("sending while paused");
endmodule
bind hcuw_uart hcuw_uart_chk u_chk (.core_clk, .rst, .uart_txd, .uart_cts_n,
  .rx_valid, .rx_ready, .rx_data, .rx_frame_err, .wake_enable, .wake_mode,
  .device_wake_in, .radio_idle, .host_needed, .device_wake_in_req, .dev_sleep_ok,
  .host_wake);

// file: verification/hcuw_uart_test.sv
// Purpose: Self-checking bench for the host link serial port.
// Assumes: Host model uses the same bit increments as the device.
// Notes:   Rates are proven by round trips rather than bit timing.
`include "hcuw_map.vh"
module hcuw_uart_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk = 1'b0, rst = 1'b1, uart_cts_n = 1'b0;
  logic        baud_load = 1'b0, tx_valid = 1'b0, rx_ready = 1'b0;
  logic        wake_enable = 1'b0, wake_mode = 1'b0, radio_idle = 1'b0;
  logic        device_wake_in = 1'b0, host_needed = 1'b0;
  logic [31:0] baud_rate = 32'h0;
  logic [7:0]  tx_data = 8'h00;
  wire         uart_rxd, uart_txd, uart_rts_n, tx_ready, rx_valid;
  wire         rx_overrun, rx_frame_err, device_wake_in_req, dev_sleep_ok, host_wake;
  wire  [7:0]  rx_data;
  int          n_fail = 0, num_checks = 0, cyc = 0, n_ferr = 0, n_ovr = 0;
  always #50 core_clk = ~core_clk;
  hcuw_uart u_dut (.core_clk, .rst, .uart_rxd, .uart_txd, .uart_rts_n,
    .uart_cts_n, .baud_rate, .baud_load, .tx_data, .tx_valid, .tx_ready,
    .rx_data, .rx_valid, .rx_ready, .rx_overrun, .rx_frame_err, .wake_enable,
    .wake_mode, .device_wake_in, .radio_idle, .host_needed, .device_wake_in_req,
    .dev_sleep_ok, .host_wake);
  hcuw_host_model u_host (.core_clk, .uart_txd, .uart_rxd);
  task automatic check(input string what, input logic [7:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (rx_frame_err === 1'b1) n_ferr++;
    if (rx_overrun === 1'b1) n_ovr++;
    // The receive fill at the top rate dominates the run length.
    if (cyc == 60000) begin
      n_fail++;
      summarize();
    end
  end
  task automatic put(input logic [7:0] b);
    tx_data <= b;
    tx_valid <= 1'b1;
    do @(posedge core_clk); while (tx_ready !== 1'b1);
  endtask
  task automatic wait_host(input int n);
    for (int i = 0; i < 4000 && u_host.n_got < n; i++)
      @(posedge core_clk);
  endtask
  task automatic rx_one(input logic [7:0] b);
    u_host.send(b, 1'b1);
    for (int i = 0; i < 400 && rx_valid !== 1'b1; i++)
      @(posedge core_clk);
    check("rx valid", rx_valid, 1'b1);
    check("rx byte", rx_data, b);
    rx_ready <= 1'b1;
    @(posedge core_clk);
    rx_ready <= 1'b0;
  endtask
  task automatic t_rate(input logic ld, input logic [31:0] bps,
                        input logic [23:0] inc);
    int n;
    n = u_host.n_got;
    baud_rate <= bps;
    baud_load <= ld;
    u_host.inc = inc;
    @(posedge core_clk);
    baud_load <= 1'b0;
    put(8'hA5);
    put(8'h3C);
    tx_valid <= 1'b0;
    wait_host(n + 1);
    check("tx byte", u_host.got, 8'hA5);
    wait_host(n + 2);
    check("tx next", u_host.got, 8'h3C);
    rx_one(8'h96);
  endtask
  task automatic t_cts();
    int n;
    n = u_host.n_got;
    uart_cts_n <= 1'b1;
    put(8'h5A);
    tx_valid <= 1'b0;
    repeat (1100) @(posedge core_clk);
    check("paused", 8'(u_host.n_got - n), 8'h00);
    uart_cts_n <= 1'b0;
    wait_host(n + 1);
    check("resumed", u_host.got, 8'h5A);
  endtask
  task automatic t_ferr();
    int n;
    n = n_ferr;
    u_host.send(8'hFF, 1'b0);
    repeat (4) @(posedge core_clk);
    check("frame err", 8'(n_ferr - n), 8'h01);
    check("dropped", rx_valid, 1'b0);
    rx_one(8'h81);
  endtask
  task automatic t_wake();
    logic [3:0] v;
    for (int i = 0; i < 16; i++) begin
      v = 4'(i);
      {wake_enable, wake_mode, device_wake_in, radio_idle} <= v;
      host_needed <= v[0] ^ v[2];
      repeat (2) @(posedge core_clk);
      check("wake req", device_wake_in_req, v[3] & !v[2] & v[1]);
      check("sleep ok", dev_sleep_ok, v[3] & v[2] & !v[1] & v[0]);
      check("host wake", host_wake, v[3] & (v[0] ^ v[2]));
    end
    wake_enable <= 1'b0;
  endtask
  // One byte waits in the output stage, so the array level lags by one.
  task automatic t_flow();
    int n;
    int thr;
    n = n_ovr;
    thr = `HCUW_FIFO_DEPTH - `HCUW_RTS_MARGIN;
    t_rate(1'b1, 32'h002DC6C0, 24'h4CCCCD);
    for (int j = 0; j <= `HCUW_FIFO_DEPTH + 1; j++) begin
      u_host.send(8'(j), 1'b1);
      if (j == thr - 1 || j == thr) begin
        repeat (3) @(posedge core_clk);
        check("rts", uart_rts_n, j == thr);
      end
    end
    repeat (4) @(posedge core_clk);
    check("overrun", 8'(n_ovr - n), 8'h01);
    for (int j = 0; j <= `HCUW_FIFO_DEPTH; j++) begin
      check("rx fill", rx_data, 8'(j));
      rx_ready <= 1'b1;
      @(posedge core_clk);
      rx_ready <= 1'b0;
      @(posedge core_clk);
    end
    check("rx drained", rx_valid, 1'b0);
    check("rts low", uart_rts_n, 1'b0);
  endtask
  task automatic t_txfull();
    int n;
    n = u_host.n_got;
    uart_cts_n <= 1'b1;
    wake_enable <= 1'b1;
    host_needed <= 1'b0;
    for (int j = 0; j <= `HCUW_FIFO_DEPTH; j++)
      put(8'(j + 7));
    tx_valid <= 1'b0;
    repeat (2) @(posedge core_clk);
    check("tx full", tx_ready, 1'b0);
    check("host pend", host_wake, 1'b1);
    uart_cts_n <= 1'b0;
    wait_host(n + 1);
    check("tx first", u_host.got, 8'h07);
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    check("txd idle", uart_txd, 1'b1);
    check("rts", uart_rts_n, 1'b0);
    check("tx ready", tx_ready, 1'b1);
    t_rate(1'b0, 32'h00000000, 24'h02F2FA);
    t_rate(1'b1, 32'h000E1000, 24'h1797CC);
    t_rate(1'b1, 32'h0016E360, 24'h266666);
    t_rate(1'b1, 32'h002DC6C0, 24'h4CCCCD);
    t_rate(1'b1, 32'h003D0900, 24'h4CCCCD);
    t_rate(1'b1, 32'h00000032, 24'h02F2FA);
    t_cts();
    t_ferr();
    t_wake();
    t_flow();
    t_txfull();
    summarize();
  end
endmodule
